/* core/acs_pkg.sv */
`default_nettype none
package acs_pkg;

    // ==========================================================
    // Timing
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned INSTR_CYCLE_NS = 100;
    localparam int unsigned INSTR_CLKS =
        (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CONV_TADS = 11;
    localparam int unsigned WAIT_TADS = 2;
    localparam int unsigned RES_BITS = 10;
    localparam int unsigned PIN_COUNT = 13;

    // ==========================================================
    // Register map, byte addresses of aligned words
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CFG = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_RESULT = 8'h0C;
    localparam logic [7:0] OFS_PORT = 8'h10;
    localparam logic [7:0] OFS_ANALOG = 8'h14;

    // ==========================================================
    // Field positions and reset values
    localparam int unsigned CTRL_ON_BIT = 0;
    localparam int unsigned CTRL_GO_BIT = 1;
    localparam int unsigned CTRL_CHS_LSB = 2;
    localparam int unsigned CFG_CLK_LSB = 0;
    localparam int unsigned CFG_ACQ_LSB = 3;
    localparam int unsigned CFG_JUST_BIT = 7;
    localparam int unsigned STAT_DONE_BIT = 0;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [7:0] CFG_WMASK = 8'hBF;
    localparam logic [12:0] ANALOG_RST = 13'h1FFF;
    localparam logic [15:0] RESULT_RST = 16'h0000;

    // ==========================================================
    // Sequencer states
    typedef enum logic [5:0] {
        ST_OFF = 6'h01,
        ST_WAIT = 6'h02,
        ST_SAMPLE = 6'h04,
        ST_DELAY = 6'h08,
        ST_ACQ = 6'h10,
        ST_CONV = 6'h20
    } acs_state_t;

    // Acquisition length in bit conversion periods
    function automatic logic [4:0] acs_acq_tads(input logic [2:0] code);
        case (code)
            3'h7: acs_acq_tads = 5'h14;
            3'h6: acs_acq_tads = 5'h10;
            3'h5: acs_acq_tads = 5'h0C;
            3'h4: acs_acq_tads = 5'h08;
            3'h3: acs_acq_tads = 5'h06;
            3'h2: acs_acq_tads = 5'h04;
            3'h1: acs_acq_tads = 5'h02;
            default: acs_acq_tads = 5'h00;
        endcase
    endfunction

endpackage
`default_nettype wire

/* core/acs_sequencer.sv */
// Behaviour
// - Programmed acquisition then automatic conversion start
// - Acquisition code maps to 0..20 periods
// - Code zero: go stops sampling at once
// - Acquisition field resets to zero
// - Done: clear go, flag, resume sampling
// - Only go flag visible while busy
// - Conversion lasts exactly eleven bit periods
// - Clock select: oscillator divisors or RC
// - Code zero delays start one instruction
// - Abort by clearing go keeps result
// - Two period wait, then resample automatically
// - Channel and direction never affect sequencing
// - Analog pins read zero on port
// - Discharge capacitor array before each sample
// - Disconnect holding capacitor at conversion start
// - Justify bit selects right or left
// - Reset turns converter off, aborts conversion
//
// Local design decisions: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer
    import acs_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire logic i_rc_clk,
    input wire logic i_cmp_above,
    input wire logic [12:0] i_port_pins,
    output logic o_sample_connect,
    output logic o_discharge,
    output logic [9:0] o_dac_code,
    output logic [3:0] o_channel_select,
    output logic o_converter_on
);

    // ==========================================================
    // Declarations
    acs_state_t state_r, state_nxt;
    logic on_r;
    logic go_r;
    logic done_r;
    logic [7:0] cfg_r;
    logic [15:0] result_r;
    logic [12:0] analog_r;
    logic [12:0] pin_s1_r, pin_s2_r;
    logic [4:0] phase_r;
    logic [9:0] trial_r;
    logic restart_r;
    logic tick;
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic addr_phase;
    logic wr_ctrl, wr_cfg, wr_status, wr_result, wr_analog;
    logic conv_done, abort;
    logic timed;
    logic [2:0] acq_code;
    logic [4:0] acq_len;
    logic [9:0] bit_mask;
    logic [9:0] kept;
    logic [9:0] sar_final;
    logic [31:0] rd_mux;

    assign acq_code = cfg_r[CFG_ACQ_LSB +: 3];
    assign acq_len = acs_acq_tads(acq_code);

    // ==========================================================
    // AHB-Lite slave, zero wait states, always OKAY
    assign addr_phase = i_hsel & i_htrans[1] & i_hready;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else begin
            wr_pend_r <= addr_phase & i_hwrite & (i_hsize == 3'h2);
            wr_addr_r <= i_haddr[7:0];
        end
    end

    assign wr_ctrl = wr_pend_r & (wr_addr_r == OFS_CTRL);
    assign wr_cfg = wr_pend_r & (wr_addr_r == OFS_CFG);
    assign wr_status = wr_pend_r & (wr_addr_r == OFS_STATUS);
    assign wr_result = wr_pend_r & (wr_addr_r == OFS_RESULT);
    assign wr_analog = wr_pend_r & (wr_addr_r == OFS_ANALOG);

    // Status carries only the done flag, no go flag and no phase bit
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (i_haddr[7:0])
            OFS_CTRL: begin
                rd_mux[CTRL_ON_BIT] = on_r;
                rd_mux[CTRL_GO_BIT] = go_r;
                rd_mux[CTRL_CHS_LSB +: 4] = o_channel_select;
            end
            OFS_CFG: rd_mux[7:0] = cfg_r;
            OFS_STATUS: rd_mux[STAT_DONE_BIT] = done_r;
            OFS_RESULT: rd_mux[15:0] = result_r;
            OFS_PORT: rd_mux[12:0] = pin_s2_r & ~analog_r;
            OFS_ANALOG: rd_mux[12:0] = analog_r;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_hrdata <= 32'h0000_0000;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end else begin
            o_hrdata <= (addr_phase & ~i_hwrite) ? rd_mux : 32'h0000_0000;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end
    end

    // ==========================================================
    // Port pin synchroniser
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pin_s1_r <= 13'h0000;
            pin_s2_r <= 13'h0000;
        end else begin
            pin_s1_r <= i_port_pins;
            pin_s2_r <= pin_s1_r;
        end
    end

    // ==========================================================
    // Control registers
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            on_r <= 1'b0;
            o_channel_select <= 4'h0;
            cfg_r <= CFG_RST;
            analog_r <= ANALOG_RST;
        end else begin
            if (wr_ctrl) begin
                on_r <= i_hwdata[CTRL_ON_BIT];
                o_channel_select <= i_hwdata[CTRL_CHS_LSB +: 4];
            end
            if (wr_cfg) begin
                cfg_r <= i_hwdata[7:0] & CFG_WMASK;
            end
            if (wr_analog) begin
                analog_r <= i_hwdata[12:0];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_converter_on <= 1'b0;
        end else begin
            o_converter_on <= wr_ctrl ? i_hwdata[CTRL_ON_BIT] : on_r;
        end
    end

    // Go is only taken when the converter was already on
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            go_r <= 1'b0;
        end else if (conv_done) begin
            go_r <= 1'b0;
        end else if (wr_ctrl) begin
            go_r <= i_hwdata[CTRL_GO_BIT] & i_hwdata[CTRL_ON_BIT]
                & on_r;
        end else if (!on_r) begin
            go_r <= 1'b0;
        end
    end

    // Completion wins over a software clear in the same cycle
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            done_r <= 1'b0;
        end else if (conv_done) begin
            done_r <= 1'b1;
        end else if (wr_status && i_hwdata[STAT_DONE_BIT]) begin
            done_r <= 1'b0;
        end
    end

    // ==========================================================
    // Bit period generator
    assign timed = (state_r == ST_WAIT) || (state_r == ST_ACQ)
        || (state_r == ST_CONV);

    acs_tad_gen u_tad (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_run(timed),
        .i_restart(abort | restart_r),
        .i_clk_sel(cfg_r[CFG_CLK_LSB +: 3]),
        .i_rc_clk(i_rc_clk),
        .o_tick(tick)
    );

    // ==========================================================
    // Sequencer; channel and pin direction take no part here
    assign abort = ~go_r & ((state_r == ST_ACQ) || (state_r == ST_CONV)
        || (state_r == ST_DELAY));
    assign conv_done = go_r & (state_r == ST_CONV) & tick
        & (phase_r == 5'(CONV_TADS - 1));

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_OFF: begin
                if (on_r) begin
                    state_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (tick && phase_r == 5'(WAIT_TADS - 1)) begin
                    state_nxt = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                if (go_r && acq_len == 5'h00) begin
                    state_nxt = ST_DELAY;
                end else if (go_r) begin
                    state_nxt = ST_ACQ;
                end
            end
            ST_DELAY: begin
                if (abort) begin
                    state_nxt = ST_WAIT;
                end else if (phase_r == 5'(INSTR_CLKS - 1)) begin
                    state_nxt = ST_CONV;
                end
            end
            ST_ACQ: begin
                if (abort) begin
                    state_nxt = ST_WAIT;
                end else if (tick && phase_r == acq_len - 5'h01) begin
                    state_nxt = ST_CONV;
                end
            end
            ST_CONV: begin
                if (abort || conv_done) begin
                    state_nxt = ST_WAIT;
                end
            end
            default: state_nxt = ST_OFF;
        endcase
        if (!on_r) begin
            state_nxt = ST_OFF;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_r <= ST_OFF;
        end else begin
            state_r <= state_nxt;
        end
    end

    // An abort mid-period restarts the divider so the wait is whole
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            restart_r <= 1'b0;
        end else begin
            restart_r <= abort;
        end
    end

    // Delay counts system clocks, the timed states count periods
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            phase_r <= 5'h00;
        end else if (state_nxt != state_r) begin
            phase_r <= 5'h00;
        end else if (state_r == ST_DELAY || (timed && tick)) begin
            phase_r <= phase_r + 5'h01;
        end
    end

    // ==========================================================
    // Successive approximation, MSB decided in the second period
    assign bit_mask = 10'(10'h200 >> (phase_r - 5'h01));
    assign kept = i_cmp_above ? trial_r : (trial_r & ~bit_mask);
    assign sar_final = kept;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            trial_r <= 10'h000;
        end else if (state_r != ST_CONV || state_nxt != ST_CONV
            || (wr_ctrl && !i_hwdata[CTRL_ON_BIT])) begin
            trial_r <= 10'h000;
        end else if (tick && phase_r == 5'h00) begin
            trial_r <= 10'h200;
        end else if (tick && phase_r < 5'(CONV_TADS - 1)) begin
            trial_r <= kept | (bit_mask >> 1);
        end
    end

    assign o_dac_code = trial_r;

    // Hardware load wins over a software write in the same cycle
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            result_r <= RESULT_RST;
        end else if (conv_done && cfg_r[CFG_JUST_BIT]) begin
            result_r <= {6'h00, sar_final};
        end else if (conv_done) begin
            result_r <= {sar_final, 6'h00};
        end else if (wr_result) begin
            result_r <= i_hwdata[15:0];
        end
    end

    // ==========================================================
    // Analog switch controls
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_sample_connect <= 1'b0;
            o_discharge <= 1'b0;
        end else begin
            o_sample_connect <= (state_nxt == ST_SAMPLE)
                || (state_nxt == ST_ACQ);
            o_discharge <= (state_nxt == ST_WAIT);
        end
    end

endmodule
`default_nettype wire

/* core/acs_tad_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module acs_tad_gen
    import acs_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_run,
    input wire logic i_restart,
    input wire logic [2:0] i_clk_sel,
    input wire logic i_rc_clk,
    output logic o_tick
);

    // ==========================================================
    // RC clock synchroniser; stages two and three feed the edge finder
    logic rc_s1_r, rc_s2_r, rc_s3_r;
    logic [5:0] cnt_r;
    logic [5:0] term;
    logic use_rc;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rc_s1_r <= 1'b0;
            rc_s2_r <= 1'b0;
            rc_s3_r <= 1'b0;
        end else begin
            rc_s1_r <= i_rc_clk;
            rc_s2_r <= rc_s1_r;
            rc_s3_r <= rc_s2_r;
        end
    end

    assign use_rc = (i_clk_sel[1:0] == 2'h3);

    // ==========================================================
    // Oscillator prescale terminal counts
    always_comb begin
        case (i_clk_sel)
            3'h0: term = 6'h01;
            3'h4: term = 6'h03;
            3'h1: term = 6'h07;
            3'h5: term = 6'h0F;
            3'h2: term = 6'h1F;
            3'h6: term = 6'h3F;
            default: term = 6'h01;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_r <= 6'h00;
            o_tick <= 1'b0;
        end else if (!i_run || i_restart) begin
            cnt_r <= 6'h00;
            o_tick <= 1'b0;
        end else if (use_rc) begin
            cnt_r <= 6'h00;
            o_tick <= rc_s2_r & ~rc_s3_r;
        end else begin
            cnt_r <= (cnt_r >= term) ? 6'h00 : cnt_r + 6'h01;
            o_tick <= (cnt_r >= term);
        end
    end

endmodule
`default_nettype wire

/* test/acs_sequencer_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_chk
    import acs_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    input wire logic [31:0] o_hrdata,
    input wire logic o_hreadyout,
    input wire logic o_hresp,
    input wire logic i_rc_clk,
    input wire logic i_cmp_above,
    input wire logic [12:0] i_port_pins,
    input wire logic o_sample_connect,
    input wire logic o_discharge,
    input wire logic [9:0] o_dac_code,
    input wire logic [3:0] o_channel_select,
    input wire logic o_converter_on
);
    // ==========================================================
    // Helper: read data phase follows a taken read address phase
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    logic rd_ph_r;
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rd_ph_r <= 1'b0;
        end else begin
            rd_ph_r <= i_hsel & i_htrans[1] & i_hready & ~i_hwrite;
        end
    end

    // ==========================================================
    // Assertions
    bus_okay_a: assert property (o_hreadyout && !o_hresp)
        else $error("bus slave stalled or answered with error");
    rdata_idle_a: assert property (!rd_ph_r |-> o_hrdata == 32'h0)
        else $error("read data outside a read data phase");
    disc_excl_a: assert property (!(o_discharge && o_sample_connect))
        else $error("discharge while sampling");
    disc_first_a: assert property ($rose(o_sample_connect) |->
        $past(o_discharge))
        else $error("sampling began without discharge");
    disc_len_a: assert property ($rose(o_discharge) |-> o_discharge [*4])
        else $error("post conversion wait too short");
    conv_start_a: assert property ($rose(o_dac_code != 10'h0) |->
        o_dac_code == 10'h200 && !o_sample_connect)
        else $error("conversion began wrongly");
    dac_idle_a: assert property (o_sample_connect || o_discharge ||
        !o_converter_on |-> o_dac_code == 10'h000)
        else $error("trial code outside conversion");
    off_quiet_a: assert property (!o_converter_on [*2] |->
        !o_sample_connect && !o_discharge)
        else $error("activity while converter off");

    // ==========================================================
    // Covers
    conv_c: cover property ($rose(o_dac_code != 10'h0));
    disc_c: cover property ($rose(o_discharge));
    read_c: cover property (rd_ph_r);
endmodule

bind acs_sequencer acs_sequencer_chk i_chk (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_hsel(i_hsel),
    .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
    .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(i_hready),
    .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .i_rc_clk(i_rc_clk), .i_cmp_above(i_cmp_above),
    .i_port_pins(i_port_pins), .o_sample_connect(o_sample_connect),
    .o_discharge(o_discharge), .o_dac_code(o_dac_code),
    .o_channel_select(o_channel_select), .o_converter_on(o_converter_on)
);
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import acs_pkg::*;
    // ==========================================================
    // Signals
    logic clk, arst_n, hsel, hwrite, rc, cmp, hready, hresp, samp, disc, on;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [12:0] pins;
    logic [9:0] dac;
    logic [3:0] chs;
    int err_total = 0;
    int comparisons = 0;
    int n;

    acs_sequencer i_acs_sequencer (
        .i_clk(clk), .i_arst_n(arst_n), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
        .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
        .o_hreadyout(hready), .o_hresp(hresp), .i_rc_clk(rc),
        .i_cmp_above(cmp), .i_port_pins(pins), .o_sample_connect(samp),
        .o_discharge(disc), .o_dac_code(dac), .o_channel_select(chs),
        .o_converter_on(on)
    );

    // ==========================================================
    // Clocks; RC clock is unrelated in phase to the bus clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        rc = 1'b0;
        #7.3;
        forever #100.3 rc = ~rc;
    end

    // ==========================================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h wanted %h", $time, seen, exp);
        end
    endtask
    task automatic near(input int seen, input int exp, input int tol);
        check(32'(seen >= exp - tol && seen <= exp + tol), 32'h1);
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        logic r;
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do begin
            @(negedge clk);
            r = hready;
            @(posedge clk);
        end while (r !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do begin
            @(negedge clk);
            r = hready;
            q = hrdata;
            @(posedge clk);
        end while (r !== 1'b1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(q, e);
    endtask
    function automatic logic pick(input int w);
        case (w)
            0: pick = samp;
            1: pick = disc;
            default: pick = (dac != 10'h0);
        endcase
    endfunction
    // Counts cycles while the chosen output keeps a level, bounded
    task automatic hold(input int w, input logic v);
        n = 0;
        @(negedge clk);
        while (pick(w) === v && n < 5000) begin
            @(negedge clk);
            n++;
        end
        check(32'(n < 5000), 32'h1);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_regs();
        rd(OFS_CFG, 32'h0);
        rd(OFS_CTRL, 32'h0);
        rd(OFS_RESULT, 32'h0);
        rd(OFS_ANALOG, 32'h1FFF);
        rd(OFS_PORT, 32'h0);
        rd(8'h18, 32'h0);
        wr(OFS_CFG, 32'hFF);
        rd(OFS_CFG, 32'hBF);
        wr(OFS_ANALOG, 32'h00F0);
        rd(OFS_PORT, 32'h1A0A);
        wr(OFS_CTRL, 32'h3);
        rd(OFS_CTRL, 32'h1);
        $display("test regs done");
    endtask
    task automatic t_acq();
        int tads[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
        for (int c = 0; c < 8; c++) begin
            cmp <= c[0];
            wr(OFS_CFG, 32'h80 | (c << 3));
            hold(0, 1'b0);
            wr(OFS_CTRL, 32'h3 | (c << 2));
            hold(0, 1'b1);
            near(n, 2 * tads[c], 3);
            hold(2, 1'b0);
            near(n, 2 + (c == 0 ? INSTR_CLKS : 0), 2);
            hold(1, 1'b0);
            near(n, 20, 3);
            hold(1, 1'b1);
            near(n, 4, 2);
            check(samp, 1'b1);
            check(chs, c[3:0]);
            rd(OFS_CTRL, 32'h1 | (c << 2));
            rd(OFS_STATUS, 32'h1);
            rd(OFS_RESULT, c[0] ? 32'h3FF : 32'h0);
            wr(OFS_STATUS, 32'h1);
        end
        $display("test acquisition done");
    endtask
    task automatic t_just();
        cmp <= 1'b1;
        wr(OFS_CFG, 32'h3);
        wr(OFS_CTRL, 32'h3);
        hold(1, 1'b0);
        rd(OFS_RESULT, 32'hFFC0);
        hold(1, 1'b1);
        $display("test justify done");
    endtask
    task automatic t_abort();
        wr(OFS_RESULT, 32'h1234);
        wr(OFS_STATUS, 32'h1);
        wr(OFS_CFG, 32'h38);
        wr(OFS_CTRL, 32'h3);
        rd(OFS_CTRL, 32'h3);
        @(negedge clk);
        check(samp & ~|dac, 1'b1);
        rd(OFS_STATUS, 32'h0);
        hold(2, 1'b0);
        rd(OFS_CTRL, 32'h3);
        wr(OFS_CTRL, 32'h1);
        hold(1, 1'b0);
        near(n, 1, 2);
        hold(1, 1'b1);
        near(n, 4, 2);
        rd(OFS_RESULT, 32'h1234);
        rd(OFS_STATUS, 32'h0);
        $display("test abort done");
    endtask
    // Two bit periods of wait show the divisor of every oscillator code or the RC period
    task automatic t_clk();
        for (int c = 0; c < 8; c++) begin
            wr(OFS_CTRL, 32'h0);
            repeat (2) @(negedge clk);
            check(samp | disc, 1'b0);
            wr(OFS_CFG, c);
            wr(OFS_CTRL, 32'h1);
            hold(1, 1'b0);
            hold(1, 1'b1);
            if ((c & 3) == 3) begin
                near(n, 14, 7);
            end else begin
                near(n, 4 << ((c >> 2) + 2 * (c & 3)), 3);
            end
        end
        $display("test clock select done");
    endtask
    task automatic t_reset();
        wr(OFS_CFG, 32'h38);
        wr(OFS_CTRL, 32'h3);
        hold(2, 1'b0);
        @(posedge clk);
        arst_n <= 1'b0;
        @(negedge clk);
        check(on | samp | disc | (|dac), 1'b0);
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        rd(OFS_CTRL, 32'h0);
        rd(OFS_CFG, 32'h0);
        $display("test reset done");
    endtask

    // ==========================================================
    // Verdict, main sequence and watchdog
    task automatic print_verdict();
        $display("counts: %0d compares, %0d mismatches", comparisons,
            err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        arst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        cmp = 1'b1;
        pins = 13'h1AAA;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        t_regs();
        t_acq();
        t_just();
        t_abort();
        t_clk();
        t_reset();
        print_verdict();
    end
    // The whole sequence needs well under 20000 clocks
    initial begin
        #1000000;
        err_total++;
        $display("unexpected at %0t: watchdog expired", $time);
        print_verdict();
    end
endmodule
`default_nettype wire
